// ### rtl/ppec_top.sv
// Pin electrical control for two ports, registers behind APB.
// Assumes direction bits and raw pin receivers are outside;
// receiver outputs are asynchronous, direction is same-clock.
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ppec_top
    import ppec_pkg::*;
#(
    parameter logic P_LARGE_PKG = 1'b1
) (
    // Clock and reset
    input  wire logic                       i_clock,
    input  wire logic                       i_nrst,
    // APB slave
    input  wire logic                       i_psel,
    input  wire logic                       i_penable,
    input  wire logic                       i_pwrite,
    input  wire logic [7:0]                 i_paddr,
    input  wire logic [31:0]                i_pwdata,
    output logic      [31:0]                o_prdata,
    output logic                            o_pready,
    output logic                            o_pslverr,
    // First port pins
    input  wire logic [ppec_pkg::PPEC_PA_PINS-1:0] i_pa_rx_schmitt,
    input  wire logic [ppec_pkg::PPEC_PA_PINS-1:0] i_pa_rx_ttl,
    output logic      [ppec_pkg::PPEC_PA_PINS-1:0] o_pa_slew_limit,
    output logic      [ppec_pkg::PPEC_PA_PINS-1:0] o_pa_read,
    output logic      [ppec_pkg::PPEC_PA_PINS-1:0] o_pa_change,
    // Second port pins
    input  wire logic [ppec_pkg::PPEC_PC_PINS-1:0] i_pc_rx,
    input  wire logic [ppec_pkg::PPEC_PC_PINS-1:0] i_pc_dir_in,
    output logic      [ppec_pkg::PPEC_PC_PINS-1:0] o_pc_read,
    output logic      [ppec_pkg::PPEC_PC_PINS-1:0] o_pc_din_buf_en,
    output logic      [ppec_pkg::PPEC_PC_PINS-1:0] o_pc_analog_en,
    output logic      [ppec_pkg::PPEC_PC_PINS-1:0] o_pc_pullup_on
);

    import ppec_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [7:0]              slew_r;
    logic [7:0]              slew_nxt;
    logic [7:0]              thresh_r;
    logic [7:0]              thresh_nxt;
    logic [7:0]              analog_r;
    logic [7:0]              analog_nxt;
    logic [7:0]              pullup_r;
    logic [7:0]              pullup_nxt;
    logic [31:0]             prdata_r;
    logic [31:0]             prdata_nxt;
    logic                    pslverr_r;
    logic                    pslverr_nxt;
    logic [PPEC_PA_PINS-1:0] pa_read_r;
    logic [PPEC_PA_PINS-1:0] pa_read_nxt;
    logic [PPEC_PA_PINS-1:0] pa_change_r;
    logic [PPEC_PA_PINS-1:0] pa_change_nxt;
    logic [PPEC_PA_PINS-1:0] pa_prev_r;
    logic [PPEC_PA_PINS-1:0] pa_prev_nxt;
    logic [PPEC_PC_PINS-1:0] pc_read_r;
    logic [PPEC_PC_PINS-1:0] pc_read_nxt;
    logic [PPEC_PA_PINS-1:0] pa_st_sync;
    logic [PPEC_PA_PINS-1:0] pa_ttl_sync;
    logic [PPEC_PC_PINS-1:0] pc_sync;
    logic [PPEC_PC_PINS-1:0] pc_din;
    logic [PPEC_PC_PINS-1:0] pc_pullup_on;
    logic [7:0]              pc_mask;
    logic                    setup;
    logic                    wr_go;
    logic                    mapped;
    logic                    read_only;

    // Upper second-port bits vanish on the small package
    localparam logic [7:0] PC_MASK_EFF = P_LARGE_PKG ? PPEC_PC_MASK_BIG
                                                     : PPEC_PC_MASK_SML;
    // Reset value masked too, so the first read is already clean
    localparam logic [7:0] ANALOG_RST_EFF = PPEC_ANALOG_RST & PC_MASK_EFF;

    assign pc_mask = PC_MASK_EFF;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    ppec_sync #(
        .W (PPEC_PA_PINS)
    ) u_sync_pa_st (
        .i_clock (i_clock),
        .i_nrst  (i_nrst),
        .i_async (i_pa_rx_schmitt),
        .o_sync  (pa_st_sync)
    );

    ppec_sync #(
        .W (PPEC_PA_PINS)
    ) u_sync_pa_ttl (
        .i_clock (i_clock),
        .i_nrst  (i_nrst),
        .i_async (i_pa_rx_ttl),
        .o_sync  (pa_ttl_sync)
    );

    ppec_sync #(
        .W (PPEC_PC_PINS)
    ) u_sync_pc (
        .i_clock (i_clock),
        .i_nrst  (i_nrst),
        .i_async (i_pc_rx),
        .o_sync  (pc_sync)
    );

    // ****************************************************************
    // Second port gating
    // ****************************************************************
    ppec_pc_pin u_pc_pin (
        .i_analog_sel (analog_r),
        .i_pullup_en  (pullup_r),
        .i_dir_in     (i_pc_dir_in),
        .i_pin_sync   (pc_sync),
        .o_din        (pc_din),
        .o_din_buf_en (o_pc_din_buf_en),
        .o_pullup_on  (pc_pullup_on)
    );

    assign o_pc_analog_en = analog_r;
    assign o_pc_pullup_on = pc_pullup_on;

    // ****************************************************************
    // APB decode
    // ****************************************************************
    assign setup  = i_psel & ~i_penable;
    assign wr_go  = i_psel & i_penable & i_pwrite & ~pslverr_r;

    always_comb
    begin
        mapped    = 1'b1;
        read_only = 1'b0;
        unique case (i_paddr)
            PPEC_OFF_SLEW,
            PPEC_OFF_THRESH,
            PPEC_OFF_ANALOG,
            PPEC_OFF_PULLUP :  read_only = 1'b0;
            PPEC_OFF_PA_READ,
            PPEC_OFF_PC_READ,
            PPEC_OFF_PU_EFF :  read_only = 1'b1;
            default :          mapped    = 1'b0;
        endcase
    end

    // ****************************************************************
    // Register file next state
    // ****************************************************************
    always_comb
    begin
        slew_nxt   = slew_r;
        thresh_nxt = thresh_r;
        analog_nxt = analog_r;
        pullup_nxt = pullup_r;
        if (wr_go)
        begin
            unique case (i_paddr)
                PPEC_OFF_SLEW :
                    slew_nxt   = i_pwdata[7:0] & PPEC_SLEW_MASK;
                PPEC_OFF_THRESH :
                    thresh_nxt = i_pwdata[7:0] & PPEC_THRESH_MASK;
                PPEC_OFF_ANALOG :
                    analog_nxt = i_pwdata[7:0] & pc_mask;
                PPEC_OFF_PULLUP :
                    pullup_nxt = i_pwdata[7:0] & pc_mask;
                default :
                    slew_nxt   = slew_r;
            endcase
        end
    end

    // ****************************************************************
    // Read data and error, captured in the setup cycle
    // ****************************************************************
    always_comb
    begin
        prdata_nxt  = prdata_r;
        pslverr_nxt = pslverr_r;
        if (setup)
        begin
            prdata_nxt  = 32'h0000_0000;
            pslverr_nxt = ~mapped | (read_only & i_pwrite);
            if (!i_pwrite)
            begin
                unique case (i_paddr)
                    PPEC_OFF_SLEW :
                        prdata_nxt[7:0] = slew_r;
                    PPEC_OFF_THRESH :
                        prdata_nxt[7:0] = thresh_r;
                    PPEC_OFF_ANALOG :
                        prdata_nxt[7:0] = analog_r;
                    PPEC_OFF_PULLUP :
                        prdata_nxt[7:0] = pullup_r;
                    PPEC_OFF_PA_READ :
                        prdata_nxt[PPEC_PA_PINS-1:0] = pa_read_r;
                    PPEC_OFF_PC_READ :
                        prdata_nxt[7:0] = pc_read_r;
                    PPEC_OFF_PU_EFF :
                        prdata_nxt[7:0] = pc_pullup_on & pc_mask;
                    default :
                        prdata_nxt = 32'h0000_0000;
                endcase
            end
        end
    end

    // ****************************************************************
    // First port input path
    // ****************************************************************
    // Threshold switch on a steady pin can itself flag a change,
    // since the two receivers may disagree near the trip point.
    always_comb
    begin
        pa_read_nxt   = pa_read_r;
        pa_prev_nxt   = pa_prev_r;
        pa_change_nxt = '0;
        for (int i = 0; i < PPEC_PA_PINS; i++)
        begin
            pa_read_nxt[i] = thresh_r[i] ? pa_st_sync[i]
                                         : pa_ttl_sync[i];
        end
        pa_prev_nxt   = pa_read_nxt;
        pa_change_nxt = pa_read_nxt ^ pa_prev_r;
    end

    // Second port read value, zero on analog pins
    always_comb
    begin
        pc_read_nxt = pc_din & pc_mask;
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            slew_r      <= PPEC_SLEW_RST;
            thresh_r    <= PPEC_THRESH_RST;
            analog_r    <= ANALOG_RST_EFF;
            pullup_r    <= PPEC_PULLUP_RST;
            prdata_r    <= 32'h0000_0000;
            pslverr_r   <= 1'b0;
        end
        else
        begin
            slew_r      <= slew_nxt;
            thresh_r    <= thresh_nxt;
            analog_r    <= analog_nxt;
            pullup_r    <= pullup_nxt;
            prdata_r    <= prdata_nxt;
            pslverr_r   <= pslverr_nxt;
        end
    end

    // Pin path kept apart from the bus registers
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            pa_read_r   <= '0;
            pa_prev_r   <= '0;
            pa_change_r <= '0;
            pc_read_r   <= '0;
        end
        else
        begin
            pa_read_r   <= pa_read_nxt;
            pa_prev_r   <= pa_prev_nxt;
            pa_change_r <= pa_change_nxt;
            pc_read_r   <= pc_read_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Zero wait states; error only flagged in the access phase
    assign o_pready  = 1'b1;
    assign o_pslverr = i_psel & i_penable & pslverr_r;
    assign o_prdata  = prdata_r;

    assign o_pa_slew_limit = slew_r[PPEC_PA_PINS-1:0];
    assign o_pa_read       = pa_read_r;
    assign o_pa_change     = pa_change_r;
    assign o_pc_read       = pc_read_r;

endmodule : ppec_top
`default_nettype wire

// ### rtl/ppec_pkg.sv
// Constants shared by the pin electrical control block.
// Assumes a 32-bit APB slave and 8-bit port registers.
package ppec_pkg;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] PPEC_OFF_SLEW     = 8'h00;
    localparam logic [7:0] PPEC_OFF_THRESH   = 8'h04;
    localparam logic [7:0] PPEC_OFF_ANALOG   = 8'h08;
    localparam logic [7:0] PPEC_OFF_PULLUP   = 8'h0C;
    localparam logic [7:0] PPEC_OFF_PA_READ  = 8'h10;
    localparam logic [7:0] PPEC_OFF_PC_READ  = 8'h14;
    localparam logic [7:0] PPEC_OFF_PU_EFF   = 8'h18;

    // ****************************************************************
    // Implemented bit masks
    // ****************************************************************
    localparam logic [7:0] PPEC_SLEW_MASK    = 8'h37;
    localparam logic [7:0] PPEC_THRESH_MASK  = 8'h3F;
    localparam logic [7:0] PPEC_PC_MASK_BIG  = 8'hFF;
    localparam logic [7:0] PPEC_PC_MASK_SML  = 8'h3F;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] PPEC_SLEW_RST     = 8'h37;
    localparam logic [7:0] PPEC_THRESH_RST   = 8'h3F;
    localparam logic [7:0] PPEC_ANALOG_RST   = 8'hFF;
    localparam logic [7:0] PPEC_PULLUP_RST   = 8'h00;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int PPEC_PA_PINS = 6;
    localparam int PPEC_PC_PINS = 8;

endpackage : ppec_pkg

// ### rtl/ppec_sync.sv
// Two-flop synchroniser for a bus of asynchronous pin levels.
// Assumes each bit is an independent level; no word coherence.
`timescale 1ns/1ps
`default_nettype none
module ppec_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         i_clock,
    input  wire logic         i_nrst,
    // Data
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // First stage is read only by the second stage
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            meta_r <= '0;
            sync_r <= '0;
        end
        else
        begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;

endmodule : ppec_sync
`default_nettype wire

// ### rtl/ppec_pc_pin.sv
// Per-pin gating for the second port: analog select and pull-up.
// Assumes direction bits come from same-clock logic, 1 = input.
`timescale 1ns/1ps
`default_nettype none
module ppec_pc_pin (
    // Configuration
    input  wire logic [7:0] i_analog_sel,
    input  wire logic [7:0] i_pullup_en,
    input  wire logic [7:0] i_dir_in,
    // Pin side
    input  wire logic [7:0] i_pin_sync,
    output logic      [7:0] o_din,
    output logic      [7:0] o_din_buf_en,
    output logic      [7:0] o_pullup_on
);

    // ****************************************************************
    // Per-pin gating
    // ****************************************************************
    for (genvar g = 0; g < 8; g++)
    begin : g_pin
        // Analog pin: digital buffer off, reads zero
        assign o_din_buf_en[g] = ~i_analog_sel[g];
        assign o_din[g]        = i_pin_sync[g] & ~i_analog_sel[g];
        // Output drive overrides the pull-up enable
        assign o_pullup_on[g]  = i_pullup_en[g] & i_dir_in[g];
    end

endmodule : ppec_pc_pin
`default_nettype wire

// ### verification/ppec_top_checker.sv
// Port checker for the pin electrical control block.
// Assumes binding into every ppec_top instance.
`timescale 1ns/1ps
`default_nettype none
module ppec_top_checker
    import ppec_pkg::*;
#(
    parameter logic P_LARGE_PKG = 1'b1
) (
    input wire logic        i_clock,
    input wire logic        i_nrst,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [7:0]  i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pslverr,
    input wire logic [5:0]  o_pa_slew_limit,
    input wire logic [5:0]  o_pa_read,
    input wire logic [5:0]  o_pa_change,
    input wire logic [7:0]  i_pc_dir_in,
    input wire logic [7:0]  o_pc_read,
    input wire logic [7:0]  o_pc_din_buf_en,
    input wire logic [7:0]  o_pc_analog_en,
    input wire logic [7:0]  o_pc_pullup_on
);
    localparam logic [31:0] PCM = P_LARGE_PKG ? 32'h0000_00FF : 32'h0000_003F;
    logic acc;
    logic wr;
    assign acc = i_psel && i_penable;
    assign wr = acc && i_pwrite;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_slew_write: assert property (wr && i_paddr == PPEC_OFF_SLEW |=>
        {26'h0, o_pa_slew_limit} == ($past(i_pwdata) & 32'h0000_0037))
        else $error("slew pins differ from written value");
    a_slew_unimpl: assert property (acc && !i_pwrite &&
        i_paddr == PPEC_OFF_SLEW |-> (o_prdata & 32'hFFFF_FFC8) == 32'h0)
        else $error("slew read shows unimplemented bits");
    a_thresh_unimpl: assert property (acc && !i_pwrite &&
        i_paddr == PPEC_OFF_THRESH |-> (o_prdata & 32'hFFFF_FFC0) == 32'h0)
        else $error("threshold read shows unimplemented bits");
    a_change_pulse: assert property (o_pa_change ==
        (o_pa_read ^ $past(o_pa_read)))
        else $error("change pulse does not follow read toggle");
    a_buffer_off: assert property (o_pc_din_buf_en == ~o_pc_analog_en)
        else $error("input buffer enable not inverse of analog");
    a_analog_read: assert property (
        (o_pc_read & $past(o_pc_analog_en)) == 8'h00)
        else $error("analog pin reads high");
    a_analog_write: assert property (wr && i_paddr == PPEC_OFF_ANALOG |=>
        {24'h0, o_pc_analog_en} == ($past(i_pwdata) & PCM))
        else $error("analog select differs from written value");
    a_pullup_write: assert property (wr && i_paddr == PPEC_OFF_PULLUP |=>
        {24'h0, o_pc_pullup_on} == ($past(i_pwdata) & PCM & {24'h0, i_pc_dir_in}))
        else $error("pull-up differs from written value");
    a_pullup_gate: assert property ((o_pc_pullup_on & ~i_pc_dir_in) == 8'h00)
        else $error("pull-up on for output pin");
    a_reset_value: assert property ($rose(i_nrst) |-> o_pa_slew_limit == 6'h37 &&
        {24'h0, o_pc_analog_en} == PCM && o_pc_pullup_on == 8'h00)
        else $error("wrong value after reset");

    c_error: cover property (acc && o_pslverr);
    c_change: cover property (o_pa_change != 6'h00);
    c_pullup: cover property (wr && i_paddr == PPEC_OFF_PULLUP);
endmodule : ppec_top_checker

bind ppec_top ppec_top_checker #(.P_LARGE_PKG(P_LARGE_PKG)) ppec_top_checker_i (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
    .o_pa_slew_limit(o_pa_slew_limit), .o_pa_read(o_pa_read),
    .o_pa_change(o_pa_change), .i_pc_dir_in(i_pc_dir_in),
    .o_pc_read(o_pc_read), .o_pc_din_buf_en(o_pc_din_buf_en),
    .o_pc_analog_en(o_pc_analog_en), .o_pc_pullup_on(o_pc_pullup_on));
`default_nettype wire

// ### verification/ppec_pin_model.sv
// Circuits outside the pins: receivers, drivers, pull-ups.
// Assumes the bench sets levels; undriven pins float.
`timescale 1ns/1ps
`default_nettype none
module ppec_pin_model (
    input  wire logic       i_clock,
    input  wire logic [5:0] i_pa_level,
    input  wire logic [5:0] i_pa_mid,
    input  wire logic [7:0] i_pc_drive,
    input  wire logic [7:0] i_pc_level,
    input  wire logic [7:0] i_pc_pullup_on,
    output logic      [5:0] o_pa_rx_schmitt,
    output logic      [5:0] o_pa_rx_ttl,
    output logic      [7:0] o_pc_rx
);
    // Floating pins wander so a stale level never passes
    logic [7:0] float_r = 8'h55;
    always @(posedge i_clock) float_r <= ~float_r;
    // Mid voltage crosses the TTL threshold only
    assign o_pa_rx_ttl = i_pa_level | i_pa_mid;
    assign o_pa_rx_schmitt = i_pa_level;
    assign o_pc_rx = (i_pc_drive & i_pc_level)
        | (~i_pc_drive & (i_pc_pullup_on | float_r));
endmodule : ppec_pin_model
`default_nettype wire

// ### verification/port_pin_electrical_control_test.sv
// Self-checking bench for the pin electrical control block.
// Assumes zero-wait APB and the pin model on the far side.
`timescale 1ns/1ps
`default_nettype none
module port_pin_electrical_control_test;
    import ppec_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr;
    logic [7:0] paddr = 8'h00, pcrx, dir_in = 8'hFF, drive = 8'h00;
    logic [7:0] level = 8'h00, pc_rd, buf_en, ana, pu_on, s_ana, s_pu;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [5:0] pa_lvl = 6'h00, pa_mid = 6'h00, sch, ttl, slew, pa_rd;
    int num_errors = 0;
    int check_count = 0;

    ppec_top ppec_top_i (.i_clock(clk), .i_nrst(nrst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_pa_rx_schmitt(sch), .i_pa_rx_ttl(ttl),
        .o_pa_slew_limit(slew), .o_pa_read(pa_rd), .o_pa_change(),
        .i_pc_rx(pcrx), .i_pc_dir_in(dir_in), .o_pc_read(pc_rd),
        .o_pc_din_buf_en(buf_en), .o_pc_analog_en(ana),
        .o_pc_pullup_on(pu_on));
    // Smaller package variant shares bus and pins, never answers reads
    ppec_top #(.P_LARGE_PKG(1'b0)) ppec_top_small_i (.i_clock(clk),
        .i_nrst(nrst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(), .o_pready(), .o_pslverr(), .i_pa_rx_schmitt(sch),
        .i_pa_rx_ttl(ttl), .o_pa_slew_limit(), .o_pa_read(),
        .o_pa_change(), .i_pc_rx(pcrx), .i_pc_dir_in(dir_in),
        .o_pc_read(), .o_pc_din_buf_en(), .o_pc_analog_en(s_ana),
        .o_pc_pullup_on(s_pu));
    ppec_pin_model ppec_pin_model_i (.i_clock(clk), .i_pa_level(pa_lvl),
        .i_pa_mid(pa_mid), .i_pc_drive(drive), .i_pc_level(level),
        .i_pc_pullup_on(pu_on), .o_pa_rx_schmitt(sch),
        .o_pa_rx_ttl(ttl), .o_pc_rx(pcrx));

    initial
    begin
        forever #2 clk = ~clk;
    end

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, input logic [31:0] exd,
                        input logic exe);
        logic [31:0] r;
        logic e;
        logic rdy;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            r = prdata;
            e = pslverr;
            rdy = pready;
        end
        while (rdy !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pslverr", {31'h0, exe}, {31'h0, e});
        if (!w && !exe)
            chk("prdata", exd, r);
    endtask : xfer

    task automatic settle;
        repeat (6) @(negedge clk);
    endtask : settle

    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        final_report();
    end

    initial
    begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        chk("slew pins", 32'h0000_0037, {26'h0, slew});
        chk("small analog", 32'h0000_003F, {24'h0, s_ana});
        xfer(1'b0, PPEC_OFF_SLEW, 32'h0, 32'h0000_0037, 1'b0);
        xfer(1'b0, PPEC_OFF_THRESH, 32'h0, 32'h0000_003F, 1'b0);
        xfer(1'b0, PPEC_OFF_ANALOG, 32'h0, 32'h0000_00FF, 1'b0);
        xfer(1'b0, PPEC_OFF_PULLUP, 32'h0, 32'h0, 1'b0);
        $display("test reset done");
        xfer(1'b1, PPEC_OFF_SLEW, 32'hFFFF_FFFF, 32'h0, 1'b0);
        xfer(1'b0, PPEC_OFF_SLEW, 32'h0, 32'h0000_0037, 1'b0);
        xfer(1'b1, PPEC_OFF_SLEW, 32'h0000_0012, 32'h0, 1'b0);
        settle();
        chk("slew pins", 32'h0000_0012, {26'h0, slew});
        xfer(1'b1, PPEC_OFF_THRESH, 32'hFFFF_FFC0, 32'h0, 1'b0);
        xfer(1'b0, PPEC_OFF_THRESH, 32'h0, 32'h0, 1'b0);
        $display("test slew done");
        pa_mid <= 6'h3F;
        settle();
        chk("port a read", 32'h0000_003F, {26'h0, pa_rd});
        xfer(1'b1, PPEC_OFF_THRESH, 32'h0000_0005, 32'h0, 1'b0);
        settle();
        chk("port a read", 32'h0000_003A, {26'h0, pa_rd});
        xfer(1'b0, PPEC_OFF_PA_READ, 32'h0, 32'h0000_003A, 1'b0);
        $display("test threshold done");
        dir_in <= 8'hFF;
        drive <= 8'hFF;
        level <= 8'hA5;
        xfer(1'b1, PPEC_OFF_ANALOG, 32'h0000_00FF, 32'h0, 1'b0);
        settle();
        chk("small analog", 32'h0000_003F, {24'h0, s_ana});
        chk("port c read", 32'h0, {24'h0, pc_rd});
        chk("buffer enable", 32'h0, {24'h0, buf_en});
        xfer(1'b1, PPEC_OFF_ANALOG, 32'h0000_000F, 32'h0, 1'b0);
        settle();
        chk("port c read", 32'h0000_00A0, {24'h0, pc_rd});
        chk("buffer enable", 32'h0000_00F0, {24'h0, buf_en});
        xfer(1'b0, PPEC_OFF_PC_READ, 32'h0, 32'h0000_00A0, 1'b0);
        $display("test analog done");
        xfer(1'b1, PPEC_OFF_ANALOG, 32'h0, 32'h0, 1'b0);
        drive <= 8'h00;
        dir_in <= 8'hF0;
        xfer(1'b1, PPEC_OFF_PULLUP, 32'h0000_00FF, 32'h0, 1'b0);
        settle();
        chk("pull-up on", 32'h0000_00F0, {24'h0, pu_on});
        chk("small pull-up", 32'h0000_0030, {24'h0, s_pu});
        chk("pulled pins", 32'h0000_00F0, {24'h0, pc_rd & 8'hF0});
        xfer(1'b0, PPEC_OFF_PU_EFF, 32'h0, 32'h0000_00F0, 1'b0);
        xfer(1'b1, PPEC_OFF_PULLUP, 32'h0, 32'h0, 1'b0);
        settle();
        chk("pull-up on", 32'h0, {24'h0, pu_on});
        xfer(1'b1, PPEC_OFF_PU_EFF, 32'h0000_00FF, 32'h0, 1'b1);
        xfer(1'b0, 8'h1C, 32'h0, 32'h0, 1'b1);
        $display("test pull-up done");
        final_report();
    end
endmodule : port_pin_electrical_control_test
`default_nettype wire
